// file: src/pulse_divider.sv
// One-cycle enable pulse every PERIOD clocks while enabled
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
	parameter int PERIOD = 800
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	output logic tick
);
	localparam int W = $clog2(PERIOD);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);
	logic [W-1:0] cnt;

	initial begin
		if (PERIOD < 2) $error("PERIOD must be at least 2");
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !en) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt == LAST);
			cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
		end
	end

	property p_tick_spacing;
		@(posedge clk) disable iff (!rst_n) tick |=> !tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("tick wider than one cycle");
endmodule
`default_nettype wire

// file: src/rx_duty_cycle_sequencer.sv
// Operating-state sequencer of a stand-alone receiver with AHB-Lite registers
// Summary of operation
// - Power-up state first: reset, crystal, calibration
// - Power-up 4 ms normal, 9.5 ms duty
// - Slow oscillator and sleep timer only in duty
// - Sleep powers all but timer; fixed 3 ms in normal mode
// - Duty sleep counted in 1 kHz ticks, configurable
// - Slow oscillator calibrated, then recalibrated periodically
// - Crystal settle only in duty, after sleep
// - Settle wait one of six values, default 310 us
// - Tune takes about 300 us, then receive
// - Receive drives data; duty ends after receive time
// - Receive time 0.04 ms steps, default 2000 ms
// - Normal mode: sleep once, tune, receive forever
// - Duty mode: sleep, settle, tune, receive, repeat
// - Data output low outside receive state
// - Clock output only in settle, tune, receive
// - Thirty-two clock frequencies, default second, off
// - Reset output copies internal power-on clear
// - Reset output rises after release delay
// - Mode option read at power-up picks sequence
`timescale 1ns/1ps
`default_nettype none
module rx_duty_cycle_sequencer
	import rx_seq_pkg::*;
#(
	parameter int PUP_OFF_CYCLES = PUP_OFF_US * CYC_PER_US,
	parameter int PUP_ON_CYCLES = PUP_ON_US * CYC_PER_US,
	parameter int ALWAYS_SLEEP_CYCLES = ALWAYS_SLEEP_US * CYC_PER_US,
	parameter int TUNE_CYCLES = TUNE_US * CYC_PER_US,
	parameter int LP_TICK_CYCLES = CLK_HZ / LP_HZ,
	parameter int RST_DELAY_CYCLES = RST_DELAY_US * CYC_PER_US
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic demod_raw,
	output logic demod_data_out,
	output logic sys_clock_out,
	output logic reset_out_n
);
	seq_cfg_t cfg;
	seq_state_t state;
	seq_state_t next_state;
	logic mode_duty;
	logic restart_req;
	logic [31:0] dwell;
	logic [31:0] dur_target;
	logic unit_en;
	logic dwell_done;
	logic lp_tick;
	logic rx_tick;
	logic lp_cal_ok;
	logic [7:0] recal_count;
	logic [9:0] recal_timer;
	logic [31:0] rst_cnt;
	logic por_done;
	logic demod_s1;
	logic demod_s2;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic clk_out_en;

	initial begin
		if (PUP_OFF_CYCLES < 1 || PUP_ON_CYCLES < 1 || TUNE_CYCLES < 1) $error("bad durations");
		if (ALWAYS_SLEEP_CYCLES < 1 || RST_DELAY_CYCLES < 1) $error("bad durations");
		if (LP_TICK_CYCLES < 2) $error("LP_TICK_CYCLES must be at least 2");
	end

	function automatic logic [2:0] state_code(input seq_state_t s);
		case (s)
			ST_PUP: state_code = 3'h0;
			ST_SLEEP: state_code = 3'h1;
			ST_SETTLE: state_code = 3'h2;
			ST_TUNE: state_code = 3'h3;
			ST_RX: state_code = 3'h4;
			default: state_code = 3'h7;
		endcase
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] a);
		case (a)
			OFS_CTRL: read_word = {29'h0, cfg.rst_en, cfg.clk_en, cfg.duty};
			OFS_CLKSEL: read_word = {27'h0, cfg.div_sel};
			OFS_SETTLE: read_word = {29'h0, cfg.settle_sel};
			OFS_SLEEP: read_word = {4'h0, cfg.sleep_ms};
			OFS_RXTIME: read_word = {5'h0, cfg.rx_units};
			OFS_STATUS: read_word = {16'h0, recal_count, 2'h0, reset_out_n, lp_cal_ok,
				mode_duty, state_code(state)};
			default: read_word = 32'h0;
		endcase
	endfunction

	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite && hsize == 3'h2;
			wr_addr <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite) begin
				hrdata <= read_word(haddr[7:0]);
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg.duty <= DEF_DUTY;
			cfg.clk_en <= DEF_CLK_EN;
			cfg.rst_en <= DEF_RST_EN;
			cfg.div_sel <= DEF_DIV_SEL;
			cfg.settle_sel <= DEF_SETTLE_SEL;
			cfg.sleep_ms <= DEF_SLEEP_MS;
			cfg.rx_units <= DEF_RX_UNITS;
			restart_req <= 1'b0;
		end else begin
			restart_req <= wr_pend && wr_addr == OFS_CTRL && hwdata[CTRL_RESTART];
			if (wr_pend) begin
				case (wr_addr)
					OFS_CTRL: begin
						cfg.duty <= hwdata[CTRL_DUTY];
						cfg.clk_en <= hwdata[CTRL_CLK_EN];
						cfg.rst_en <= hwdata[CTRL_RST_EN];
					end
					OFS_CLKSEL: cfg.div_sel <= hwdata[4:0];
					OFS_SETTLE: cfg.settle_sel <= (hwdata[2:0] > 3'h5) ? 3'h5 : hwdata[2:0];
					OFS_SLEEP: begin
						cfg.sleep_ms <= (hwdata[27:0] < MIN_SLEEP_MS) ? MIN_SLEEP_MS : hwdata[27:0];
					end
					OFS_RXTIME: begin
						cfg.rx_units <= (hwdata[26:0] < MIN_RX_UNITS) ? MIN_RX_UNITS : hwdata[26:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Slow oscillator tick runs only in duty mode
	pulse_divider #(.PERIOD(LP_TICK_CYCLES)) u_lp_div (
		.clk(clk),
		.rst_n(rst_n),
		.en(mode_duty),
		.tick(lp_tick)
	);

	pulse_divider #(.PERIOD(RX_TICK_CYCLES)) u_rx_div (
		.clk(clk),
		.rst_n(rst_n),
		.en(state == ST_RX && mode_duty),
		.tick(rx_tick)
	);

	// Durations and sequencing
	always_comb begin
		unit_en = 1'b1;
		dur_target = 32'(TUNE_CYCLES);
		next_state = state;
		case (state)
			ST_PUP: begin
				dur_target = mode_duty ? 32'(PUP_ON_CYCLES) : 32'(PUP_OFF_CYCLES);
				next_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (mode_duty) begin
					unit_en = lp_tick;
					dur_target = {4'h0, cfg.sleep_ms};
					next_state = ST_SETTLE;
				end else begin
					dur_target = 32'(ALWAYS_SLEEP_CYCLES);
					next_state = ST_TUNE;
				end
			end
			ST_SETTLE: begin
				dur_target = 32'(settle_us(cfg.settle_sel) * CYC_PER_US);
				next_state = ST_TUNE;
			end
			ST_TUNE: begin
				dur_target = 32'(TUNE_CYCLES);
				next_state = ST_RX;
			end
			ST_RX: begin
				unit_en = mode_duty && rx_tick;
				dur_target = {5'h0, cfg.rx_units};
				next_state = ST_SLEEP;
			end
			default: next_state = ST_PUP;
		endcase
		dwell_done = unit_en && (dwell >= dur_target - 32'h1);
	end

	always_ff @(posedge clk) begin
		if (!rst_n || restart_req) begin
			state <= ST_PUP;
			dwell <= 32'h0;
		end else if (dwell_done) begin
			state <= next_state;
			dwell <= 32'h0;
		end else if (unit_en) begin
			dwell <= dwell + 32'h1;
		end
	end

	// Mode option is sampled only when power-up starts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_duty <= DEF_DUTY;
		end else if (restart_req) begin
			mode_duty <= cfg.duty;
		end
	end

	// Slow oscillator calibration and periodic recalibration
	always_ff @(posedge clk) begin
		if (!rst_n || restart_req) begin
			lp_cal_ok <= 1'b0;
			recal_count <= 8'h00;
			recal_timer <= 10'h000;
		end else if (mode_duty) begin
			if (state == ST_PUP && dwell_done) begin
				lp_cal_ok <= 1'b1;
			end
			if (lp_cal_ok && lp_tick) begin
				if (recal_timer == 10'(RECAL_PERIOD_MS - 1)) begin
					recal_timer <= 10'h000;
					recal_count <= recal_count + 8'h01;
				end else begin
					recal_timer <= recal_timer + 10'h001;
				end
			end
		end
	end

	// Reset output after the release delay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_cnt <= 32'h0;
			por_done <= 1'b0;
			reset_out_n <= 1'b0;
		end else begin
			if (!por_done) begin
				rst_cnt <= rst_cnt + 32'h1;
				por_done <= (rst_cnt == 32'(RST_DELAY_CYCLES - 1));
			end
			reset_out_n <= por_done || !cfg.rst_en;
		end
	end

	// Demodulated data path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			demod_s1 <= 1'b0;
			demod_s2 <= 1'b0;
			demod_data_out <= 1'b0;
		end else begin
			demod_s1 <= demod_raw;
			demod_s2 <= demod_s1;
			demod_data_out <= (state == ST_RX) && demod_s2;
		end
	end

	assign clk_out_en = cfg.clk_en
		&& (state == ST_SETTLE || state == ST_TUNE || state == ST_RX);
	sys_clock_gen u_clk_gen (
		.clk(clk),
		.rst_n(rst_n),
		.en(clk_out_en),
		.div_sel(cfg.div_sel),
		.clk_out(sys_clock_out)
	);

	sequence s_sleep_done;
		state == ST_SLEEP && dwell_done && !restart_req;
	endsequence
	sequence s_tune_done;
		state == ST_TUNE && dwell_done && !restart_req;
	endsequence
	property p_pup_first;
		@(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> state == ST_PUP && dwell == 32'h0;
	endproperty
	a_pup_first: assert property (p_pup_first) else $error("not in power-up after reset");
	property p_pup_len;
		@(posedge clk) disable iff (!rst_n)
			state == ST_PUP ##1 state == ST_SLEEP |->
			$past(dwell) == 32'($past(mode_duty) ? PUP_ON_CYCLES - 1 : PUP_OFF_CYCLES - 1);
	endproperty
	a_pup_len: assert property (p_pup_len) else $error("power-up length wrong");
	property p_lp_off;
		@(posedge clk) disable iff (!rst_n) !mode_duty |=> ##1 !lp_tick;
	endproperty
	a_lp_off: assert property (p_lp_off) else $error("slow tick in normal mode");
	property p_duty_order;
		@(posedge clk) disable iff (!rst_n) mode_duty ##0 s_sleep_done |=> state == ST_SETTLE;
	endproperty
	a_duty_order: assert property (p_duty_order) else $error("sleep not to settle");
	property p_normal_order;
		@(posedge clk) disable iff (!rst_n) !mode_duty ##0 s_sleep_done |=> state == ST_TUNE;
	endproperty
	a_normal_order: assert property (p_normal_order) else $error("sleep not to tune");
	property p_tune_rx;
		@(posedge clk) disable iff (!rst_n)
			s_tune_done |=> state == ST_RX ##1 (state == ST_RX || restart_req || $past(restart_req));
	endproperty
	a_tune_rx: assert property (p_tune_rx) else $error("tune not followed by receive");
	property p_rx_forever;
		@(posedge clk) disable iff (!rst_n)
			state == ST_RX && !mode_duty && !restart_req |=> state == ST_RX;
	endproperty
	a_rx_forever: assert property (p_rx_forever) else $error("left receive");
	property p_data_low;
		@(posedge clk) disable iff (!rst_n) state != ST_RX |=> !demod_data_out;
	endproperty
	a_data_low: assert property (p_data_low) else $error("data out high outside receive");
	property p_rst_out;
		@(posedge clk) disable iff (!rst_n)
			$rose(reset_out_n) && cfg.rst_en |-> rst_cnt == 32'(RST_DELAY_CYCLES);
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset out released early");
endmodule
`default_nettype wire

// file: src/rx_seq_pkg.sv
// Shared constants, types and register map of the receiver state sequencer
package rx_seq_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int PUP_OFF_US = 4000;
	localparam int PUP_ON_US = 9500;
	localparam int ALWAYS_SLEEP_US = 3000;
	localparam int TUNE_US = 300;
	localparam int RX_UNIT_US = 40;
	localparam int LP_HZ = 1000;
	localparam int RST_DELAY_US = 500;
	localparam int RX_TICK_CYCLES = RX_UNIT_US * CYC_PER_US;
	localparam int RECAL_PERIOD_MS = 1000;
	localparam logic [27:0] MIN_SLEEP_MS = 28'h3;
	localparam logic [26:0] MIN_RX_UNITS = 27'h1;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLKSEL = 8'h04;
	localparam logic [7:0] OFS_SETTLE = 8'h08;
	localparam logic [7:0] OFS_SLEEP = 8'h0c;
	localparam logic [7:0] OFS_RXTIME = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	localparam int CTRL_DUTY = 0;
	localparam int CTRL_CLK_EN = 1;
	localparam int CTRL_RST_EN = 2;
	localparam int CTRL_RESTART = 3;
	localparam int STAT_MODE = 3;
	localparam int STAT_LPCAL = 4;
	localparam int STAT_RSTO = 5;
	localparam int STAT_RECAL_LSB = 8;

	localparam logic DEF_DUTY = 1'b1;
	localparam logic DEF_CLK_EN = 1'b0;
	localparam logic DEF_RST_EN = 1'b1;
	localparam logic [4:0] DEF_DIV_SEL = 5'h01;
	localparam logic [2:0] DEF_SETTLE_SEL = 3'h2;
	localparam logic [27:0] DEF_SLEEP_MS = 28'h3;
	localparam logic [26:0] DEF_RX_UNITS = 27'hc350;

	typedef enum {ST_PUP, ST_SLEEP, ST_SETTLE, ST_TUNE, ST_RX} seq_state_t;

	typedef struct packed {
		logic duty;
		logic clk_en;
		logic rst_en;
		logic [4:0] div_sel;
		logic [2:0] settle_sel;
		logic [27:0] sleep_ms;
		logic [26:0] rx_units;
	} seq_cfg_t;

	function automatic int settle_us(input logic [2:0] sel);
		case (sel)
			3'h0: settle_us = 78;
			3'h1: settle_us = 155;
			3'h2: settle_us = 310;
			3'h3: settle_us = 620;
			3'h4: settle_us = 1240;
			default: settle_us = 2480;
		endcase
	endfunction
endpackage

// file: src/sys_clock_gen.sv
// Divided system clock output, clk / (2 * (div_sel + 1)), 50 percent duty
`timescale 1ns/1ps
`default_nettype none
module sys_clock_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [4:0] div_sel,
	output logic clk_out
);
	logic [4:0] cnt;

	always_ff @(posedge clk) begin
		if (!rst_n || !en) begin
			cnt <= 5'h00;
			clk_out <= 1'b0;
		end else if (cnt == div_sel) begin
			cnt <= 5'h00;
			clk_out <= ~clk_out;
		end else begin
			cnt <= cnt + 5'h01;
		end
	end

	property p_off_low;
		@(posedge clk) disable iff (!rst_n) !en |=> !clk_out;
	endproperty
	a_off_low: assert property (p_off_low) else $error("clock out active while off");

	property p_half_period;
		@(posedge clk) disable iff (!rst_n)
			$changed(clk_out) && $past(en) && en |-> $past(cnt) == $past(div_sel);
	endproperty
	a_half_period: assert property (p_half_period) else $error("clock out edge off count");
endmodule
`default_nettype wire

// file: verification/mcu_model.sv
// Controller-side model that samples the receiver outputs and times them
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic demod_data_out,
	input wire logic sys_clock_out,
	input wire logic reset_out_n,
	output int last_hi,
	output int last_gap,
	output int runs,
	output int clk_per,
	output int clk_rises,
	output int rst_dly
);
	int hi;
	int gap;
	int since_rise;
	logic prev_clk;
	always @(posedge clk) begin
		prev_clk <= sys_clock_out;
		if (!rst_n) begin
			{hi, gap, runs, last_hi, last_gap} <= '0;
			{clk_per, clk_rises, since_rise, rst_dly} <= '0;
		end else begin
			if (!reset_out_n) begin
				rst_dly <= rst_dly + 1;
			end
			if (demod_data_out) begin
				hi <= hi + 1;
				if (gap > 0) begin
					last_gap <= gap;
				end
				gap <= 0;
			end else begin
				gap <= gap + 1;
				if (hi > 0) begin
					last_hi <= hi;
					runs <= runs + 1;
				end
				hi <= 0;
			end
			if (sys_clock_out && !prev_clk) begin
				clk_per <= since_rise;
				clk_rises <= clk_rises + 1;
				since_rise <= 1;
			end else begin
				since_rise <= since_rise + 1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench of the receiver state sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rx_seq_pkg::*;
	localparam int P_ON = 80;
	localparam int P_OFF = 40;
	localparam int A_SLP = 30;
	localparam int TN = 20;
	localparam int LP = 10;
	localparam int RD = 25;
	localparam int E_DUTY = P_ON + 78 * CYC_PER_US + TN;
	localparam int E_GAP = 78 * CYC_PER_US + TN;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic demod_raw = 1'b1;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic demod_data_out;
	logic sys_clock_out;
	logic reset_out_n;
	int last_hi;
	int last_gap;
	int runs;
	int clk_per;
	int clk_rises;
	int rst_dly;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int t0;
	int t;
	int c0;
	logic [31:0] r;
	logic [7:0] def_a [6] = '{OFS_CTRL, OFS_CLKSEL, OFS_SETTLE, OFS_SLEEP, OFS_RXTIME, 8'h18};
	logic [31:0] def_v [6] = '{32'h5, 32'h1, 32'h2, 32'h3, 32'hc350, 32'h0};

	rx_duty_cycle_sequencer #(.PUP_OFF_CYCLES(P_OFF), .PUP_ON_CYCLES(P_ON),
		.ALWAYS_SLEEP_CYCLES(A_SLP), .TUNE_CYCLES(TN), .LP_TICK_CYCLES(LP),
		.RST_DELAY_CYCLES(RD)) rx_duty_cycle_sequencer_inst (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .demod_raw(demod_raw), .demod_data_out(demod_data_out),
		.sys_clock_out(sys_clock_out), .reset_out_n(reset_out_n));

	mcu_model mcu_model_inst (.clk(clk), .rst_n(rst_n), .demod_data_out(demod_data_out),
		.sys_clock_out(sys_clock_out), .reset_out_n(reset_out_n), .last_hi(last_hi),
		.last_gap(last_gap), .runs(runs), .clk_per(clk_per), .clk_rises(clk_rises),
		.rst_dly(rst_dly));

	always #25 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(nm, q, e);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		chk("reset out in reset", {31'h0, reset_out_n}, 32'h0);
		rst_n <= 1'b1;
		t0 = cycles;
		for (int i = 0; i < 6; i++) begin
			rd("default", def_a[i], def_v[i]);
		end
		wr(OFS_SETTLE, 32'h7);
		rd("settle clamp", OFS_SETTLE, 32'h5);
		wr(OFS_SLEEP, 32'h1);
		rd("sleep clamp", OFS_SLEEP, 32'h3);
		wr(OFS_RXTIME, 32'h0);
		rd("rx time clamp", OFS_RXTIME, 32'h1);
		wr(OFS_SETTLE, 32'h0);
		wr(OFS_CLKSEL, 32'h3);
		wr(OFS_CTRL, 32'h7);
		rd("ctrl", OFS_CTRL, 32'h7);
		$display("register test done");
		while (demod_data_out !== 1'b1) @(posedge clk);
		t = cycles - t0;
		chk("duty first rx", {31'h0, t >= E_DUTY + 2 * LP && t <= E_DUTY + 3 * LP + 8},
			32'h1);
		bus(OFS_STATUS, 1'b0, 32'h0, r);
		chk("duty status", {29'h0, r[5:3]}, 32'h7);
		while (runs < 2) @(posedge clk);
		chk("rx length", {31'h0, last_hi >= RX_TICK_CYCLES - 2 && last_hi <= RX_TICK_CYCLES + 3},
			32'h1);
		chk("off gap", {31'h0, last_gap >= E_GAP + 2 * LP - 2 && last_gap <= E_GAP + 3 * LP + 4},
			32'h1);
		chk("clock period", 32'(clk_per), 32'h8);
		chk("reset delay", 32'(rst_dly), 32'(RD + 1));
		$display("duty test done");
		wr(OFS_CTRL, 32'he);
		t0 = cycles;
		repeat (5) @(posedge clk);
		c0 = clk_rises;
		repeat (55) @(posedge clk);
		chk("clock quiet", 32'(clk_rises), 32'(c0));
		while (demod_data_out !== 1'b1) @(posedge clk);
		t = cycles - t0;
		chk("always first rx", {31'h0, t >= P_OFF + A_SLP + TN && t <= P_OFF + A_SLP + TN + 8},
			32'h1);
		repeat (3000) @(posedge clk);
		bus(OFS_STATUS, 1'b0, 32'h0, r);
		chk("always status", {26'h0, r[5:0]}, 32'h24);
		demod_raw <= 1'b0;
		repeat (4) @(posedge clk);
		chk("data low", {31'h0, demod_data_out}, 32'h0);
		demod_raw <= 1'b1;
		repeat (4) @(posedge clk);
		chk("data high", {31'h0, demod_data_out}, 32'h1);
		chk("clock rising", {31'h0, clk_rises > c0}, 32'h1);
		$display("always test done");
		test_done();
	end
endmodule
`default_nettype wire
